// >>> pkg/strap_defines.svh
// Holds the constants for the reset strap configuration latch.
// Assumes inclusion by bare name from the package and the design files.
`ifndef STRAP_DEFINES_SVH
`define STRAP_DEFINES_SVH
`define ADDR_W            5
`define ADDR_DEFAULT      5'h01
`define REG_ADDR_W        4
`define OFS_MGMT_ADDR     4'h0
`define OFS_MODE          4'h1
`define OFS_RELEASE       4'h2
`define OFS_STATUS        4'h3
`define MODE_AN_BIT       2
`define MODE_HI_BIT       1
`define MODE_LO_BIT       0
`define ADV_10_HALF       4'h1
`define ADV_10_FULL       4'h2
`define ADV_100_HALF      4'h4
`define ADV_100_FULL      4'h8
`define ADV_NONE          4'h0
`define MODE_W            3
`define ADDR_PAD          3'h0
`define MODE_PAD          5'h00
`define STATUS_PAD        5'h00
`define RDATA_IDLE        8'h00
`define PD_RESET          1'h1
`define FLAG_CLEAR        1'h0
`endif

// >>> pkg/strap_pkg.sv
// Holds the types shared by the strap configuration latch.
// Assumes strap_defines.svh is on the include path.
`include "strap_defines.svh"
package strap_pkg;
    typedef logic [`ADDR_W-1:0] mgmt_addr_t;
    typedef enum logic [2:0]
    {
        ST_RESET     = 3'b001,
        ST_POWERDOWN = 3'b010,
        ST_RUN       = 3'b100
    } boot_state_e;
endpackage : strap_pkg

// >>> src/strap_sample.sv
// Holds one strap sampling flop that follows its pin only while reset is held.
// Assumes i_hold is high while the synchronised reset is still held low.
`timescale 1ns/10ps
`default_nettype none
module strap_sample
#(
    parameter int W = 1
)
(
    input  wire logic         i_clk,
    input  wire logic         i_hold,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_pin,
    input  wire logic [W-1:0] i_sw_value,
    output logic      [W-1:0] o_value
);
    always_ff @(posedge i_clk)
    begin
        if (i_hold)
            o_value <= i_pin;      // see (RULE_01)
        else if (i_load)
            o_value <= i_sw_value; // see (RULE_12)
    end
endmodule : strap_sample
`default_nettype wire

// >>> src/reset_strap_config_latch.sv
// Holds the reset strap configuration latch with its software strapping registers.
// Assumes strap pins are synchronous to i_clk and steady while i_rst_b is held low.
//
// Summary of operation
// (RULE_01) Strap pin levels are sampled while hardware reset is held active.
// (RULE_02) After reset, pins change freely without touching the latched values.
// (RULE_03) Five address straps latch into the management address register each reset.
// (RULE_04) Every management address from zero to thirty-one is accepted.
// (RULE_05) Unstrapped pins give address one: bit zero pulled up, others down.
// (RULE_06) Select strap low enters software strapping and holds power-down.
// (RULE_07) In software strapping mode the host may program strapping registers.
// (RULE_08) A release register access ends power-down; until then stay down.
// (RULE_09) Select strap high starts normally from the hardware straps.
// (RULE_10) Negotiation on: pattern 00 advertises 10M both duplexes, 01 100M.
// (RULE_11) Negotiation off with both selects low forces 10M half duplex.
// (RULE_12) Latched values hold until next reset, except software strapping writes.
`timescale 1ns/10ps
`default_nettype none
`include "strap_defines.svh"
module reset_strap_config_latch
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    input  wire logic [`ADDR_W-1:0]   i_mgmt_addr_strap,
    input  wire logic                 i_soft_config_select,
    input  wire logic                 i_autoneg_enable_strap,
    input  wire logic                 i_advertise_sel_hi,
    input  wire logic                 i_advertise_sel_lo,
    input  wire logic [`REG_ADDR_W-1:0] i_addr,
    input  wire logic [7:0]           i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [7:0]           o_rdata,
    output strap_pkg::mgmt_addr_t     o_mgmt_addr,
    output logic                      o_power_down,
    output logic                      o_autoneg_enable,
    output logic      [3:0]           o_advertise,
    output logic                      o_force_speed_100,
    output logic                      o_force_full_duplex
);
    import strap_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic        rst_meta;
    logic        rst_sync;
    boot_state_e state;
    boot_state_e next_state;
    mgmt_addr_t  addr_q;
    logic [`MODE_W-1:0] mode_q;
    logic        sel_q;

    // Reset asserts at once so the straps start following their pins; release waits
    // two edges so that no flop leaves reset on a partly settled edge.
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Straps follow the pins while reset is low and freeze at release; the
    // sampling flops take no asynchronous reset because they capture pin levels.
    wire hold        = ~rst_sync;
    wire soft_mode   = (state == ST_POWERDOWN);
    wire hit_mgmt    = (i_addr == `OFS_MGMT_ADDR);
    wire hit_mode    = (i_addr == `OFS_MODE);
    wire hit_release = (i_addr == `OFS_RELEASE);
    wire hit_status  = (i_addr == `OFS_STATUS);
    // Writes land only in software power-down; once running the values are frozen.
    wire wr_addr     = i_wr & soft_mode & hit_mgmt;       // see (RULE_07)
    wire wr_mode     = i_wr & soft_mode & hit_mode;       // see (RULE_07)
    wire release_hit = (i_wr | i_rd) & hit_release;      // see (RULE_08)
    wire [`ADDR_W-1:0] addr_wdata = i_wdata[`ADDR_W-1:0];
    wire [`MODE_W-1:0] mode_wdata = i_wdata[`MODE_W-1:0];
    wire [`MODE_W-1:0] mode_pins  = {i_autoneg_enable_strap, i_advertise_sel_hi, i_advertise_sel_lo};

    strap_sample #(.W(`ADDR_W)) u_addr
    (
        .i_clk      (i_clk),
        .i_hold     (hold),
        .i_load     (wr_addr),
        .i_pin      (i_mgmt_addr_strap),              // see (RULE_03)
        .i_sw_value (addr_wdata),
        .o_value    (addr_q)
    );

    strap_sample #(.W(`MODE_W)) u_mode
    (
        .i_clk      (i_clk),
        .i_hold     (hold),
        .i_load     (wr_mode),
        .i_pin      (mode_pins),
        .i_sw_value (mode_wdata),
        .o_value    (mode_q)
    );

    strap_sample #(.W(1)) u_sel
    (
        .i_clk      (i_clk),
        .i_hold     (hold),
        .i_load     (1'b0),                           // see (RULE_02)
        .i_pin      (i_soft_config_select),
        .i_sw_value (1'b0),
        .o_value    (sel_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Power-down is left only by a release access; a high select strap skips it.
    always_comb
    begin
        next_state = state;
        case (state)
            ST_RESET:     next_state = sel_q ? ST_RUN : ST_POWERDOWN; // see (RULE_06) (RULE_09)
            ST_POWERDOWN: next_state = release_hit ? ST_RUN : ST_POWERDOWN; // see (RULE_08)
            ST_RUN:       next_state = ST_RUN;            // see (RULE_12)
            default:      next_state = ST_RESET;
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            state <= ST_RESET;
        else
            state <= next_state;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode bits as latched at reset or as last written by the host.
    wire       an       = mode_q[`MODE_AN_BIT];
    wire       s_hi     = mode_q[`MODE_HI_BIT];
    wire       s_lo     = mode_q[`MODE_LO_BIT];
    wire       running  = (state == ST_RUN);
    wire [3:0] adv_10   = `ADV_10_HALF | `ADV_10_FULL;
    wire [3:0] adv_100  = `ADV_100_HALF | `ADV_100_FULL;
    wire [3:0] adv_an   = s_lo ? adv_100 : adv_10;            // see (RULE_10)
    wire [3:0] adv_next = an ? adv_an : `ADV_NONE;

    ////////////////////////////////////////////////////////////////////////////
    // Read selection; unused bits and unmapped offsets read as zero.
    // A read of the release offset returns zero but still counts as the release access.
    wire [7:0] status   = {`STATUS_PAD, sel_q, soft_mode, running};
    wire [7:0] rd_addr  = {`ADDR_PAD, addr_q};
    wire [7:0] rd_mode  = {`MODE_PAD, mode_q};
    wire [7:0] rd_mux   = hit_mgmt   ? rd_addr :
                          hit_mode   ? rd_mode :
                          hit_status ? status  : `RDATA_IDLE;

    ////////////////////////////////////////////////////////////////////////////
    // Next values of the outputs, each registered by its own short flop below.
    wire [7:0] next_rdata      = i_rd ? rd_mux : `RDATA_IDLE;
    wire       next_power_down = (next_state != ST_RUN);     // see (RULE_06) (RULE_08)
    wire       next_force_100  = ~an & s_hi;                 // see (RULE_11)
    wire       next_force_full = ~an & s_lo;                 // see (RULE_11)

    ////////////////////////////////////////////////////////////////////////////
    // Outputs show their defaults while reset is held. The address default
    // matches the weak pulls, so software sees the same address before and after.
    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            o_rdata <= `RDATA_IDLE;
        else
            o_rdata <= next_rdata;
    end

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            o_mgmt_addr <= `ADDR_DEFAULT;                    // see (RULE_05)
        else
            o_mgmt_addr <= addr_q;                           // see (RULE_04)
    end

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            o_power_down <= `PD_RESET;
        else
            o_power_down <= next_power_down;
    end

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            o_autoneg_enable <= `FLAG_CLEAR;
        else
            o_autoneg_enable <= an;
    end

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            o_advertise <= `ADV_NONE;
        else
            o_advertise <= adv_next;
    end

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            o_force_speed_100 <= `FLAG_CLEAR;
        else
            o_force_speed_100 <= next_force_100;
    end

    always_ff @(posedge i_clk or negedge rst_sync)
    begin
        if (!rst_sync)
            o_force_full_duplex <= `FLAG_CLEAR;
        else
            o_force_full_duplex <= next_force_full;
    end
endmodule : reset_strap_config_latch
`default_nettype wire

// >>> dv/strap_properties.sv
// Assertions on the strap latch ports.
// Assumes it is bound to reset_strap_config_latch.
`timescale 1ns/10ps
`default_nettype none
module strap_props
(
    input wire logic            i_clk,
    input wire logic            i_rst_b,
    input wire logic [3:0]      i_addr,
    input wire logic            i_wr,
    input wire logic            i_rd,
    input wire logic [7:0]      o_rdata,
    input wire strap_pkg::mgmt_addr_t o_mgmt_addr,
    input wire logic            o_power_down,
    input wire logic [3:0]      o_advertise
);
    logic [2:0] up_n;
    logic       wa_q, wm_q, rel_q;
    wire        up = &up_n;
    wire        wa = i_wr && i_addr == 4'h0;
    wire        wm = i_wr && i_addr == 4'h1;
    wire        rel = (i_wr || i_rd) && i_addr == 4'h2;
    // Outputs settle some edges after reset, so most checks wait for the count.
    always_ff @(posedge i_clk or negedge i_rst_b)
        if (!i_rst_b)
            {up_n, wa_q, wm_q, rel_q} <= '0;
        else
            {up_n, wa_q, wm_q, rel_q} <= {up_n + {2'h0, !up}, wa, wm, rel};
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    a_addr_hold: assert property (up && !wa && !wa_q |=> $stable(o_mgmt_addr)) else $error("addr");
    a_mode_hold: assert property (up && !wm && !wm_q |=> $stable(o_advertise)) else $error("mode");
    a_pd_stays: assert property (up && o_power_down && !rel && !rel_q |=> o_power_down)
        else $error("pd left");
    a_pd_off: assert property (up && !o_power_down |=> !o_power_down) else $error("pd back");
    a_rd_idle: assert property (up && !i_rd |=> o_rdata == 8'h00) else $error("idle");
    a_rd_unmap: assert property (up && i_rd && i_addr > 4'h3 |=> o_rdata == 8'h00) else $error("unmap");
    a_rd_addr: assert property (up && i_rd && i_addr == 4'h0 && !wa_q |=>
        o_rdata == {3'h0, $past(o_mgmt_addr)}) else $error("rd addr");
    a_reset_pd: assert property (up_n == 3'h1 |-> o_power_down && o_mgmt_addr == 5'h01)
        else $error("reset");
endmodule : strap_props
bind reset_strap_config_latch strap_props u_props
(
    .i_clk        (i_clk),
    .i_rst_b      (i_rst_b),
    .i_addr       (i_addr),
    .i_wr         (i_wr),
    .i_rd         (i_rd),
    .o_rdata      (o_rdata),
    .o_mgmt_addr  (o_mgmt_addr),
    .o_power_down (o_power_down),
    .o_advertise  (o_advertise)
);
`default_nettype wire

// >>> dv/strap_board.sv
// Board straps on the shared pins, then their later life as data outputs.
// Assumes the bench sets the strap choice on the same edge as it pulls reset low.
`timescale 1ns/10ps
`default_nettype none
module strap_board
(
    input wire logic       i_clk,
    input wire logic       i_rst_b,
    input wire logic       i_fit,
    input wire logic [8:0] i_strap,
    output logic     [8:0] o_pin
);
    logic [1:0] hold_n;
    // Without resistors the address pins fall to their weak pulls.
    wire  [8:0] held = i_fit ? i_strap : {5'h01, i_strap[3:0]};
    always_ff @(posedge i_clk)
    begin
        hold_n <= !i_rst_b ? 2'h0 : hold_n + {1'b0, hold_n != 2'h3};
        o_pin  <= (!i_rst_b || hold_n != 2'h3) ? held : ~o_pin;
    end
endmodule : strap_board
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench: board model on the strap pins, bench as host.
// Assumes the design, board model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import strap_pkg::*;
    logic       i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, fit = 1;
    logic [3:0] i_addr = '0, o_advertise;
    logic [7:0] i_wdata = '0, o_rdata;
    logic [8:0] strap = '0, pin;
    logic [4:0] i_mgmt_addr_strap;
    logic       i_soft_config_select, i_autoneg_enable_strap, i_advertise_sel_hi, i_advertise_sel_lo;
    mgmt_addr_t o_mgmt_addr;
    logic       o_power_down, o_autoneg_enable, o_force_speed_100, o_force_full_duplex;
    int         mismatches = 0, n_tests = 0;
    assign {i_mgmt_addr_strap, i_soft_config_select} = pin[8:3];
    assign {i_autoneg_enable_strap, i_advertise_sel_hi, i_advertise_sel_lo} = pin[2:0];
    strap_board board (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_fit(fit), .i_strap(strap), .o_pin(pin));
    reset_strap_config_latch dut
    (
        .i_clk                  (i_clk),
        .i_rst_b                (i_rst_b),
        .i_mgmt_addr_strap      (i_mgmt_addr_strap),
        .i_soft_config_select   (i_soft_config_select),
        .i_autoneg_enable_strap (i_autoneg_enable_strap),
        .i_advertise_sel_hi     (i_advertise_sel_hi),
        .i_advertise_sel_lo     (i_advertise_sel_lo),
        .i_addr                 (i_addr),
        .i_wdata                (i_wdata),
        .i_wr                   (i_wr),
        .i_rd                   (i_rd),
        .o_rdata                (o_rdata),
        .o_mgmt_addr            (o_mgmt_addr),
        .o_power_down           (o_power_down),
        .o_autoneg_enable       (o_autoneg_enable),
        .o_advertise            (o_advertise),
        .o_force_speed_100      (o_force_speed_100),
        .o_force_full_duplex    (o_force_full_duplex)
    );
    initial
    begin
        forever #12.5 i_clk = ~i_clk;
    end
    initial
    begin
        repeat (3000) @(posedge i_clk);
        mismatches++;
        test_done;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : chk
    task automatic boot(input logic [8:0] s, input logic f);
        @(posedge i_clk);
        strap <= s;
        fit <= f;
        i_rst_b <= 1'b0;
        repeat (16) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (5) @(posedge i_clk);
        #1;
    endtask : boot
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= w;
        i_rd <= !w;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        i_rd <= 1'b0;
        #1;
        if (!w)
            chk(o_rdata, d);
        repeat (w) @(posedge i_clk);
        #1;
    endtask : acc
    task automatic t_strapped;
        boot({5'h1f, 4'b1101}, 1'b1);
        chk(8'(o_mgmt_addr), 8'h1f);
        chk(8'(o_advertise), 8'h0c);
        acc(1'b1, 4'h0, 8'h05);
        acc(1'b1, 4'h2, 8'h00);
        acc(1'b0, 4'h0, 8'h1f);
        acc(1'b0, 4'h1, 8'h05);
        acc(1'b0, 4'h3, 8'h05);
        acc(1'b0, 4'hf, 8'h00);
        chk(8'(o_power_down), 8'h00);
    endtask : t_strapped
    task automatic t_default;
        boot({5'h1a, 4'b1100}, 1'b0);
        chk(8'(o_mgmt_addr), 8'h01);
        chk(8'(o_advertise), 8'h03);
    endtask : t_default
    task automatic t_soft;
        boot(9'h000, 1'b1);
        chk(8'(o_mgmt_addr), 8'h00);
        chk({5'h00, o_autoneg_enable, o_force_speed_100, o_force_full_duplex}, 8'h00);
        acc(1'b0, 4'h3, 8'h02);
        acc(1'b1, 4'h0, 8'h15);
        acc(1'b1, 4'h1, 8'h03);
        chk({5'h00, o_autoneg_enable, o_force_speed_100, o_force_full_duplex}, 8'h03);
        chk(8'(o_advertise), 8'h00);
        acc(1'b1, 4'h1, 8'h05);
        acc(1'b0, 4'h1, 8'h05);
        acc(1'b0, 4'h0, 8'h15);
        chk(8'(o_mgmt_addr), 8'h15);
        chk(8'(o_advertise), 8'h0c);
        chk(8'(o_power_down), 8'h01);
        acc(1'b1, 4'h2, 8'h00);
        chk(8'(o_power_down), 8'h00);
    endtask : t_soft
    task automatic t_release_rd;
        boot({5'h00, 4'b0010}, 1'b0);
        chk(8'(o_mgmt_addr), 8'h01);
        chk({5'h00, o_autoneg_enable, o_force_speed_100, o_force_full_duplex}, 8'h02);
        chk(8'(o_power_down), 8'h01);
        acc(1'b0, 4'h2, 8'h00);
        chk(8'(o_power_down), 8'h00);
        acc(1'b0, 4'h3, 8'h01);
        acc(1'b1, 4'h0, 8'h1e);
        acc(1'b0, 4'h0, 8'h01);
    endtask : t_release_rd
    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    initial
    begin
        t_strapped;
        t_default;
        t_soft;
        t_release_rd;
        test_done;
    end
endmodule : testbench
`default_nettype wire
